// File: hdl/pin_sync.sv
// Two-stage synchroniser with level and falling-edge outputs
`timescale 1ns/1ns
module pin_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic pin_in,
    output logic      level,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign fall  = prev_r & ~sync_r;
endmodule

// File: hdl/reset_controller_status_regs.sv
// Reset controller command, status and mode registers with state logic
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "rst_ctrl_regs.svh"
module reset_controller_status_regs
    import rst_ctrl_pkg::*;
#(
    parameter int CNT_W = 17
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   backup_rstn,
    input  wire logic                   slow_clk,
    input  wire logic                   wdt_reset_active,
    input  wire logic                   wdt_proc_only,
    input  wire logic [`RC_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    input  wire logic                   rst_pin_in,
    output logic                        rst_pin_out,
    output logic                        rst_pin_oe,
    output logic                        cpu_reset,
    output logic                        periph_reset,
    output logic                        sw_reset_busy,
    output logic                        reset_unit_irq
);
    function automatic logic key_ok(input logic [31:0] d);
        key_ok = (d[`RC_KEY_HI:`RC_KEY_LO] == `RC_KEY_VAL);
    endfunction

    rc_state_t            state_r;
    rc_state_t            state_nxt;
    rc_cause_t            cause_r;
    rc_mode_t             mode_r;
    rc_cmd_t              cmd_r;
    logic [2:0]           phase_r;
    logic                 fall_seen_r;
    logic                 slow_q_r;
    logic                 ext_drv_r;
    logic                 own_low_r;
    logic [CNT_W-1:0]     ext_cnt_r;
    logic [31:0]          rdata_r;

    logic                 pin_level;
    logic                 pin_fall;
    logic                 slow_tick;
    logic                 wr_cmd;
    logic                 wr_mode;
    logic                 rd_status;
    logic                 cmd_any;
    logic                 sw_accept;
    logic                 user_enter;
    logic                 soft_done;
    logic                 user_done;
    logic                 wdog_enter;
    logic                 wdog_done;
    logic                 ext_start;
    logic [CNT_W-1:0]     ext_len;
    logic [31:0]          status_word;
    logic [31:0]          mode_word;
    logic [31:0]          rd_word;

    pin_sync u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_in   (rst_pin_in),
        .level    (pin_level),
        .fall     (pin_fall)
    );

    assign slow_tick = slow_clk & ~slow_q_r;

    assign wr_cmd    = reg_wr & (reg_addr == `RC_CMD_OFS)
                       & key_ok(reg_wdata);
    assign wr_mode   = reg_wr & (reg_addr == `RC_MODE_OFS)
                       & key_ok(reg_wdata);
    assign rd_status = reg_rd & (reg_addr == `RC_STATUS_OFS);

    assign cmd_any = reg_wdata[`RC_CMD_CPU_BIT]
                     | reg_wdata[`RC_CMD_PERIPH_BIT]
                     | reg_wdata[`RC_CMD_PIN_BIT];

    assign sw_accept = wr_cmd & cmd_any & (state_r == ST_IDLE)
                       & ~wdt_reset_active;

    assign user_enter = mode_r.pin_en & ~pin_level & ~own_low_r
                        & ~wdt_reset_active;

    assign soft_done = (state_r == ST_SOFT) & slow_tick
                       & (phase_r[1:0] == `RC_SW_SLOW_CYC - 2'h1);

    assign user_done = (state_r == ST_USER) & pin_level & slow_tick
                       & (phase_r == `RC_USER_SLOW_CYC - 3'h1);

    assign wdog_enter = wdt_reset_active & (state_r != ST_WDOG);
    assign wdog_done  = (state_r == ST_WDOG) & ~wdt_reset_active;

    assign ext_len = CNT_W'(1) << ({1'b0, mode_r.pulse_len} + 5'h1);

    assign ext_start = (sw_accept & reg_wdata[`RC_CMD_PIN_BIT])
                       | (wdog_enter & ~wdt_proc_only);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (wdt_reset_active) begin
                    state_nxt = ST_WDOG;
                end else if (sw_accept) begin
                    state_nxt = ST_SOFT;
                end else if (user_enter) begin
                    state_nxt = ST_USER;
                end
            end
            ST_SOFT: begin
                if (wdt_reset_active) begin
                    state_nxt = ST_WDOG;
                end else if (soft_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_USER: begin
                if (user_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WDOG: begin
                if (wdog_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_r  <= ST_IDLE;
            slow_q_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            slow_q_r <= slow_clk;
        end
    end

    // Phase counter for soft and user exit
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_r <= 3'h0;
        end else if (state_nxt != state_r) begin
            phase_r <= 3'h0;
        end else if (state_r == ST_USER && !pin_level) begin
            phase_r <= 3'h0;
        end else if (slow_tick) begin
            phase_r <= phase_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cmd_r <= '0;
        end else if (sw_accept) begin
            cmd_r.cpu    <= reg_wdata[`RC_CMD_CPU_BIT];
            cmd_r.periph <= reg_wdata[`RC_CMD_PERIPH_BIT];
            cmd_r.pin    <= reg_wdata[`RC_CMD_PIN_BIT];
        end else if (state_r != ST_SOFT) begin
            cmd_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!backup_rstn) begin
            cause_r <= rc_cause_t'(`RC_ST_RST_BACKUP >> `RC_ST_CAUSE_LO);
        end else if (!rstn) begin
            cause_r <= rc_cause_t'(`RC_ST_RST_MAIN >> `RC_ST_CAUSE_LO);
        end else if (wdog_done) begin
            cause_r <= CAUSE_WDOG;
        end else if (soft_done && cmd_r.cpu) begin
            cause_r <= CAUSE_SOFT;
        end else if (user_done) begin
            cause_r <= CAUSE_USER;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!backup_rstn) begin
            fall_seen_r <= 1'(`RC_ST_RST_BACKUP >> `RC_ST_FALL_BIT);
        end else if (!rstn) begin
            fall_seen_r <= 1'(`RC_ST_RST_MAIN >> `RC_ST_FALL_BIT);
        end else if (pin_fall) begin
            fall_seen_r <= 1'b1;
        end else if (rd_status) begin
            fall_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!backup_rstn) begin
            mode_r.pin_en    <= 1'(`RC_MODE_RST >> `RC_MODE_PIN_EN_BIT);
            mode_r.irq_en    <= 1'(`RC_MODE_RST >> `RC_MODE_IRQ_EN_BIT);
            mode_r.pulse_len <= 4'(`RC_MODE_RST >> `RC_MODE_LEN_LO);
        end else if (wr_mode) begin
            mode_r.pin_en    <= reg_wdata[`RC_MODE_PIN_EN_BIT];
            mode_r.irq_en    <= reg_wdata[`RC_MODE_IRQ_EN_BIT];
            mode_r.pulse_len <= reg_wdata[`RC_MODE_LEN_HI:`RC_MODE_LEN_LO];
        end
    end

    // pin driven low for pulse length
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ext_drv_r <= 1'b0;
            ext_cnt_r <= '0;
        end else if (ext_start) begin
            ext_drv_r <= 1'b1;
            ext_cnt_r <= ext_len;
        end else if (ext_drv_r && slow_tick) begin
            ext_cnt_r <= ext_cnt_r - CNT_W'(1);
            if (ext_cnt_r == CNT_W'(1)) begin
                ext_drv_r <= 1'b0;
            end
        end
    end

    // Own drive must not look like a user reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            own_low_r <= 1'b0;
        end else if (ext_start) begin
            own_low_r <= 1'b1;
        end else if (!ext_drv_r && pin_level) begin
            own_low_r <= 1'b0;
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`RC_ST_FALL_BIT] = fall_seen_r;
        status_word[`RC_ST_CAUSE_HI:`RC_ST_CAUSE_LO] = cause_r;
        status_word[`RC_ST_LEVEL_BIT] = pin_level;
        status_word[`RC_ST_BUSY_BIT] = (state_r == ST_SOFT);
    end

    always_comb begin
        mode_word = 32'h0;
        mode_word[`RC_MODE_PIN_EN_BIT] = mode_r.pin_en;
        mode_word[`RC_MODE_IRQ_EN_BIT] = mode_r.irq_en;
        mode_word[`RC_MODE_LEN_HI:`RC_MODE_LEN_LO] = mode_r.pulse_len;
    end

    assign rd_word = (reg_addr == `RC_STATUS_OFS) ? status_word :
                     (reg_addr == `RC_MODE_OFS)   ? mode_word   :
                                                    32'h0;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            rdata_r <= rd_word;
        end else begin
            rdata_r <= 32'h0;
        end
    end

    assign reg_rdata = rdata_r;

    assign cpu_reset = (state_r == ST_WDOG) | (state_r == ST_USER)
                       | ((state_r == ST_SOFT) & cmd_r.cpu);

    assign periph_reset = ((state_r == ST_WDOG) & ~wdt_proc_only)
                          | (state_r == ST_USER)
                          | ((state_r == ST_SOFT) & cmd_r.periph);

    assign sw_reset_busy = (state_r == ST_SOFT);

    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = ext_drv_r;

    assign reset_unit_irq = fall_seen_r & mode_r.irq_en & ~mode_r.pin_en;
endmodule

// File: hdl/rst_ctrl_pkg.sv
// Types shared by the reset controller register block
package rst_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SOFT = 2'b01,
        ST_USER = 2'b10,
        ST_WDOG = 2'b11
    } rc_state_t;

    typedef enum logic [2:0] {
        CAUSE_GENERAL = 3'b000,
        CAUSE_WAKEUP  = 3'b001,
        CAUSE_WDOG    = 3'b010,
        CAUSE_SOFT    = 3'b011,
        CAUSE_USER    = 3'b100
    } rc_cause_t;

    typedef struct packed {
        logic [3:0] pulse_len;
        logic       irq_en;
        logic       pin_en;
    } rc_mode_t;

    typedef struct packed {
        logic pin;
        logic periph;
        logic cpu;
    } rc_cmd_t;

endpackage

// File: hdl/rst_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RST_CTRL_REGS_SVH
`define RST_CTRL_REGS_SVH

`define RC_ADDR_W          8
`define RC_CMD_OFS         8'h00
`define RC_STATUS_OFS      8'h04
`define RC_MODE_OFS        8'h08

`define RC_KEY_HI          31
`define RC_KEY_LO          24
`define RC_KEY_VAL         8'ha5

`define RC_CMD_CPU_BIT     0
`define RC_CMD_PERIPH_BIT  2
`define RC_CMD_PIN_BIT     3

`define RC_ST_FALL_BIT     0
`define RC_ST_CAUSE_LO     8
`define RC_ST_CAUSE_HI     10
`define RC_ST_LEVEL_BIT    16
`define RC_ST_BUSY_BIT     17

`define RC_MODE_PIN_EN_BIT 0
`define RC_MODE_IRQ_EN_BIT 4
`define RC_MODE_LEN_LO     8
`define RC_MODE_LEN_HI     11

`define RC_ST_RST_MAIN     32'h0000_0001
`define RC_ST_RST_BACKUP   32'h0000_0000
`define RC_MODE_RST        32'h0000_0000

`define RC_SW_SLOW_CYC     2'h2
`define RC_USER_SLOW_CYC   3'h4

`endif

// File: tb/pin_partner.sv
// Board devices sharing the open-drain reset line, with its pull-up
`timescale 1ns/1ns
module pin_partner (
    input  wire logic drv_oe,
    input  wire logic drv_out,
    input  wire logic ext_low,
    output logic      pin
);
    // Any party may pull low, the pull-up wins otherwise
    assign pin = !(drv_oe && !drv_out) && !ext_low;
endmodule

// File: tb/rc_chk.sv
// Port checker for the reset controller register block
`timescale 1ns/1ns
module rc_chk (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        wdt_reset_active,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        rst_pin_in,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe,
    input wire logic        cpu_reset,
    input wire logic        periph_reset,
    input wire logic        sw_reset_busy,
    input wire logic        reset_unit_irq
);
    logic       prev_r;
    logic [2:0] stab_r;
    wire        key_ok = reg_wdata[31:24] == 8'ha5;
    wire        cmd_wr = reg_wr && reg_addr == 8'h00;
    wire        cmd_go = cmd_wr && key_ok && |{reg_wdata[3:2], reg_wdata[0]}
                         && !sw_reset_busy && !wdt_reset_active && !cpu_reset;
    wire        st_rd  = reg_rd && reg_addr == 8'h04;
    wire        calm   = stab_r >= 3'h4;

    // Cycles the pin input has held its level
    always_ff @(posedge core_clk) begin
        prev_r <= rst_pin_in;
        if (!rstn || rst_pin_in != prev_r)
            stab_r <= 3'h0;
        else if (stab_r != 3'h7)
            stab_r <= stab_r + 3'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_cmd_start;
        cmd_go |=> sw_reset_busy && cpu_reset == $past(reg_wdata[0])
                   && periph_reset == $past(reg_wdata[2]);
    endproperty
    a_cmd_start: assert property (p_cmd_start)
        else $error("command did not start reset");

    property p_pin_cmd;
        cmd_go && reg_wdata[3] |=> rst_pin_oe && !rst_pin_out;
    endproperty
    a_pin_cmd: assert property (p_pin_cmd)
        else $error("pin command did not pull pin");

    property p_bad_key;
        cmd_wr && !key_ok && !sw_reset_busy |=> !sw_reset_busy;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key command accepted");

    property p_wdog;
        wdt_reset_active && !sw_reset_busy |=> !sw_reset_busy;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("command accepted in watchdog reset");

    property p_busy_len;
        $rose(sw_reset_busy) |-> sw_reset_busy[*2] ##[1:998] !sw_reset_busy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("software reset length wrong");

    property p_level;
        st_rd && calm |=> reg_rdata[16] == $past(rst_pin_in);
    endproperty
    a_level: assert property (p_level)
        else $error("pin level bit wrong");

    property p_rd_clear;
        st_rd && calm |=> !reset_unit_irq;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status read left irq high");

    property p_reserved;
        st_rd |=> reg_rdata[31:18] == 14'h0 && reg_rdata[15:11] == 5'h0
                  && reg_rdata[7:1] == 7'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("status reserved bits set");

    property p_wo_rd;
        reg_rd && reg_addr != 8'h04 && reg_addr != 8'h08 |=> reg_rdata == 32'h0;
    endproperty
    a_wo_rd: assert property (p_wo_rd)
        else $error("command or unmapped read not zero");
endmodule

bind reset_controller_status_regs rc_chk u_chk (
    .core_clk(core_clk), .rstn(rstn), .wdt_reset_active(wdt_reset_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .cpu_reset(cpu_reset), .periph_reset(periph_reset),
    .sw_reset_busy(sw_reset_busy), .reset_unit_irq(reset_unit_irq)
);

// File: tb/testbench.sv
// Self-checking bench for the reset controller register block
`timescale 1ns/1ns
module testbench;
    import rst_ctrl_pkg::*;
    logic        core_clk, rstn, backup_rstn, wdt_reset_active, wdt_proc_only;
    logic        reg_wr, reg_rd, ext_low, rst_pin_in, rst_pin_oe, rst_pin_out;
    logic        cpu_reset, periph_reset, sw_reset_busy, reset_unit_irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  sdiv = 2'h0;
    logic [3:0]  cmds [5] = '{4'h1, 4'h4, 4'h8, 4'h5, 4'hd};
    int          fails = 0, n_tests = 0, cycles = 0;
    wire         slow_clk = sdiv[1];

    reset_controller_status_regs u_dut (
        .core_clk(core_clk), .rstn(rstn), .backup_rstn(backup_rstn),
        .slow_clk(slow_clk), .wdt_reset_active(wdt_reset_active),
        .wdt_proc_only(wdt_proc_only), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .cpu_reset(cpu_reset), .periph_reset(periph_reset),
        .sw_reset_busy(sw_reset_busy), .reset_unit_irq(reset_unit_irq)
    );
    pin_partner u_pin (.drv_oe(rst_pin_oe), .drv_out(rst_pin_out),
                       .ext_low(ext_low), .pin(rst_pin_in));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Slow tick every 4 cycles, and the hang limit
    always @(posedge core_clk) begin
        sdiv <= sdiv + 2'h1;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            print_verdict;
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic chkb(input string s, input logic e, input logic g);
        chk(s, {31'h0, e}, {31'h0, g});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [31:0] st_exp(input logic f, input logic [2:0] c);
        return {15'h0, 1'b1, 5'h0, c, 7'h0, f};
    endfunction

    initial begin
        logic [31:0] d, w;
        logic [2:0]  cs;
        logic [3:0]  cm, ln;
        int          n, e;
        void'($urandom(19009));
        {rstn, backup_rstn, wdt_reset_active, wdt_proc_only} = 4'h0;
        {reg_wr, reg_rd, ext_low} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        cs = CAUSE_GENERAL;
        cyc(4);
        rstn <= 1'b1;
        backup_rstn <= 1'b1;
        cyc(3);
        rd(8'h04, d);
        chk("status", st_exp(1'b0, cs), d);
        rd(8'h08, d);
        chk("mode", 32'h0, d);
        w = {8'ha5, 24'($urandom)};
        wr(8'h08, w);
        wr(8'h08, {8'h5a, 24'($urandom)});
        rd(8'h08, d);
        chk("mode", w & 32'h0000_0f11, d);
        @(posedge core_clk);
        rstn <= 1'b0;
        cyc(4);
        rstn <= 1'b1;
        cyc(3);
        rd(8'h08, d);
        chk("mode", w & 32'h0000_0f11, d);
        rd(8'h04, d);
        chk("status", st_exp(1'b1, cs), d);
        rd(8'h10, d);
        chk("unmapped", 32'h0, d);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, {8'ha5, 19'h0, k[1], 3'h0, k[0]});
            rd(8'h04, d);
            @(posedge core_clk);
            ext_low <= 1'b1;
            cyc(4 + $urandom_range(9));
            #1 chkb("cpu_reset", k[0], cpu_reset);
            @(posedge core_clk);
            ext_low <= 1'b0;
            cyc(40);
            #1 chkb("irq", k[1] & !k[0], reset_unit_irq);
            if (k[0])
                cs = CAUSE_USER;
            rd(8'h04, d);
            chk("status", st_exp(1'b1, cs), d);
            chkb("irq", 1'b0, reset_unit_irq);
            rd(8'h04, d);
            chk("status", st_exp(1'b0, cs), d);
        end
        $display("test pin fall done");
        for (int k = 0; k < 5; k++) begin
            cm = cmds[k];
            ln = 4'($urandom_range(2));
            wr(8'h08, {8'ha5, 12'h0, ln, 7'h0, 1'b1});
            wr(8'h00, {8'h5a, 20'h0, cm});
            #1 chkb("busy", 1'b0, sw_reset_busy);
            wr(8'h00, {8'ha5, 20'h0, cm});
            #1 chkb("busy", 1'b1, sw_reset_busy);
            chkb("cpu_reset", cm[0], cpu_reset);
            chkb("periph_reset", cm[2], periph_reset);
            chkb("pin_oe", cm[3], rst_pin_oe);
            if (!cm[3]) begin
                wr(8'h00, 32'ha500_0008);
                #1 chkb("pin_oe", 1'b0, rst_pin_oe);
            end
            n = 0;
            while (sw_reset_busy === 1'b1 && n < 40) begin
                @(posedge core_clk);
                #1 n++;
            end
            chkb("busy_len", 1'b1, n < 10);
            chkb("cpu_reset", 1'b0, cpu_reset);
            e = 4 << (ln + 1);
            while (rst_pin_oe === 1'b1 && n < 100) begin
                @(posedge core_clk);
                #1 n++;
            end
            if (cm[3])
                chkb("pin_len", 1'b1, n + 6 >= e && n <= e + 6);
            cyc(4);
            if (cm[0])
                cs = CAUSE_SOFT;
            rd(8'h04, d);
            chk("status", st_exp(cm[3], cs), d);
        end
        $display("test command done");
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            wdt_proc_only <= k[0];
            wdt_reset_active <= 1'b1;
            wr(8'h00, 32'ha500_0001);
            #1 chkb("busy", 1'b0, sw_reset_busy);
            chkb("cpu_reset", 1'b1, cpu_reset);
            chkb("pin_oe", !k[0], rst_pin_oe);
            @(posedge core_clk);
            ext_low <= 1'b1;
            cyc(6);
            ext_low <= 1'b0;
            cyc(4);
            wdt_reset_active <= 1'b0;
            cyc(60);
            #1 chkb("cpu_reset", 1'b0, cpu_reset);
            cs = CAUSE_WDOG;
            rd(8'h04, d);
            chk("status", st_exp(1'b1, cs), d);
        end
        $display("test watchdog done");
        print_verdict;
    end
endmodule
